// ===== rtl/mfs_pkg.sv
// Overview of operation
// - Stop mode 011b: decelerate to brake entry speed, then all high sides on for brake time.
// - Braking stop below brake entry speed skips deceleration and brakes at once.
// - After the brake time every transistor is switched off (high impedance).
// - Stop mode 100b: ramp speed reference to spin-down limit, then high impedance.
// - Stop mode 101b: decelerate, then DC current through one phase pattern for brake time.
// - Align pattern angle comes from configured angle or last commutation angle.
// - Phase current limited to align current ceiling during align braking.
// - Extent 0: pulses only while driving; 1: until back-EMF falls below cutoff.
// - One speed pulse every N electrical cycles, N from divider, 2 to 30 poles.
// - Motor lock holds speed pulse output high.
// - Open loop: 00 follow drive, 01 hold high, 10 follow first start only.
// - Supply cap enabled restricts speed reference to keep estimated current under cap.
// - Status flag shows the supply cap limiting the speed reference.
// - Any actionable fault drives the active-low fault output low.
// - Alarm routing set: actionable faults also drive the alarm pin high.
// - Report-only faults: fault pin low without routing, alarm only with routing.
// - Priority latched, slow retry, fast retry, report; coinciding retries wait longer time.
// - Latched fault keeps outputs off until clear; retry faults recover after retry time.
// - Fault reporting lags fault response by at most 200 ms.
// - Latched fault clears within 200 ms of the clear command.
// - Stop mode 000b switches all transistors off immediately.
// - Stop mode 010b: decelerate, all low sides on for brake time, then high impedance.
package mfs_pkg;
	localparam int          MFS_CLK_HZ        = 50_000_000;
	localparam int          MFS_TICK_MS       = 1;
	localparam int          MFS_MS_CYCLES     = MFS_CLK_HZ / 1000 * MFS_TICK_MS;
	localparam int          MFS_REPORT_LAG_MS = 200;
	localparam int          MFS_CLEAR_LAG_MS  = 200;
	localparam logic [15:0] MFS_RETRY_SLOW_MS = 16'h03e8;
	localparam logic [15:0] MFS_RETRY_FAST_MS = 16'h01f4;
	localparam logic [15:0] MFS_RAMP_STEP     = 16'h0010;
	localparam logic [15:0] MFS_CAP_STEP      = 16'h0010;

	localparam logic [2:0]  MFS_REG_CTRL   = 3'h0;
	localparam logic [2:0]  MFS_REG_SPEED  = 3'h1;
	localparam logic [2:0]  MFS_REG_BRAKE  = 3'h2;
	localparam logic [2:0]  MFS_REG_LIMIT  = 3'h3;
	localparam logic [2:0]  MFS_REG_BEMF   = 3'h4;
	localparam logic [2:0]  MFS_REG_STATUS = 3'h5;

	localparam int          MFS_F_MODE     = 0;
	localparam int          MFS_F_EXTENT   = 3;
	localparam int          MFS_F_POLICY   = 4;
	localparam int          MFS_F_DIV      = 6;
	localparam int          MFS_F_ANGSEL   = 10;
	localparam int          MFS_F_ALARM    = 11;
	localparam int          MFS_F_CAPEN    = 12;
	localparam int          MFS_F_CLEAR    = 31;
	localparam logic [31:0] MFS_CTRL_MASK  = 32'h00001fff;
	localparam logic [31:0] MFS_CTRL_RST   = 32'h00000040;
	localparam logic [31:0] MFS_BEMF_MASK  = 32'h0000ffff;

	localparam logic [2:0]  MFS_STOP_COAST = 3'h0;
	localparam logic [2:0]  MFS_STOP_LSBRK = 3'h2;
	localparam logic [2:0]  MFS_STOP_HSBRK = 3'h3;
	localparam logic [2:0]  MFS_STOP_SPIN  = 3'h4;
	localparam logic [2:0]  MFS_STOP_ALIGN = 3'h5;

	localparam logic [1:0]  MFS_OL_FOLLOW  = 2'h0;
	localparam logic [1:0]  MFS_OL_HIGH    = 2'h1;
	localparam logic [1:0]  MFS_OL_FIRST   = 2'h2;

	typedef enum logic [2:0] {MFS_RUN, MFS_DECEL, MFS_SPIN, MFS_BRAKE, MFS_HIZ} mfs_stop_e;

	typedef struct packed {
		logic latched;
		logic retry_slow;
		logic retry_fast;
		logic report_only;
	} mfs_fault_s;

	typedef struct packed {
		logic [2:0] hs;
		logic [2:0] ls;
	} mfs_gate_s;

	// six sectors; low sides are the complement so current flows through one pattern
	function automatic mfs_gate_s mfs_align_pattern(input logic [15:0] angle);
		logic [18:0] prod;
		logic [2:0]  hs;
		prod = {3'h0, angle} * 19'h00006;
		case (prod[18:16])
			3'h0:    hs = 3'h1;
			3'h1:    hs = 3'h3;
			3'h2:    hs = 3'h2;
			3'h3:    hs = 3'h6;
			3'h4:    hs = 3'h4;
			default: hs = 3'h5;
		endcase
		return '{hs: hs, ls: ~hs};
	endfunction

	function automatic logic [31:0] mfs_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction
endpackage

// ===== rtl/mfs_tick.sv
`timescale 1ns/1ns
module mfs_tick import mfs_pkg::*; #(
	parameter int CYCLES = MFS_MS_CYCLES
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// periodic strobe
	output logic      tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} mfs_tick_s;

	mfs_tick_s s_r;
	mfs_tick_s s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt >= 32'(CYCLES - 1))
		begin
			s_nxt.cnt = 32'h0;
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.cnt = s_r.cnt + 32'h1;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick;
endmodule // mfs_tick

// ===== rtl/mfs_pulse_div.sv
`timescale 1ns/1ns
module mfs_pulse_div import mfs_pkg::*; (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// half electrical cycle edges and divider
	input  wire logic       half_cycle,
	input  wire logic [3:0] divider,
	input  wire logic       enable,
	// divided square wave
	output logic            pulse
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       pulse;
	} mfs_div_s;

	mfs_div_s   s_r;
	mfs_div_s   s_nxt;
	logic [3:0] n_eff;

	// toggling every N half cycles gives one full period per N electrical cycles
	always_comb
	begin
		n_eff = (divider == 4'h0) ? 4'h1 : divider;
		s_nxt = s_r;
		if (!enable)
			s_nxt = '0;
		else if (half_cycle)
		begin
			if (s_r.cnt >= n_eff - 4'h1)
			begin
				s_nxt.cnt = 4'h0;
				s_nxt.pulse = ~s_r.pulse;
			end
			else
				s_nxt.cnt = s_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pulse = s_r.pulse;
endmodule // mfs_pulse_div

// ===== rtl/mfs_supervisor.sv
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
module mfs_supervisor import mfs_pkg::*; #(
	parameter int TICK_CYCLES = MFS_MS_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// motor control core
	input  wire logic        stop_cmd,
	input  wire logic        start_cmd,
	input  wire logic [15:0] speed_ref_in,
	input  wire logic [15:0] motor_speed,
	input  wire logic [15:0] supply_current_est,
	input  wire logic [15:0] bemf_level,
	input  wire logic [15:0] commutation_angle,
	input  wire mfs_gate_s   drive_gate,
	input  wire logic        half_cycle,
	input  wire logic        open_loop,
	input  wire logic        motor_lock,
	input  wire logic        wake,
	output logic [15:0]      speed_ref_out,
	output logic [15:0]      phase_current_limit,
	// power stage
	output mfs_gate_s        gate_out,
	// fault sources and pins
	input  wire mfs_fault_s  fault_in,
	output logic             fault_out_n,
	output logic             alarm_out,
	output logic             speed_pulse_output
);
	typedef struct packed {
		mfs_stop_e   state;
		logic [31:0] ctrl;
		logic [31:0] speed;
		logic [31:0] brake;
		logic [31:0] limit;
		logic [31:0] bemf;
		logic [31:0] rdata;
		logic        ack;
		logic [15:0] brake_cnt;
		logic [15:0] ref_val;
		logic [15:0] cap_ref;
		logic [15:0] last_angle;
		logic        latched;
		logic        slow_seen;
		logic        retry_pend;
		logic [15:0] retry_cnt;
		logic        first_start;
		logic        ol_d;
		mfs_gate_s   gate;
		logic [15:0] cur_lim;
		logic [15:0] ref_out;
		logic        pulse;
		logic        fault_n;
		logic        alarm;
	} mfs_state_s;

	mfs_state_s  s_r;
	mfs_state_s  s_nxt;
	logic        tick;
	logic        div_pulse;
	logic        div_en;
	logic        clear_req;
	logic        outputs_off;
	logic        driving;
	logic        pulse_active;
	logic        ol_hold;
	logic        cap_limiting;
	logic [15:0] capped_ref;
	logic [15:0] ramp_tgt;
	logic [16:0] ramp_sum;
	logic [15:0] ramp_dn;
	logic [16:0] cap_up;
	logic [15:0] align_angle;
	logic [15:0] retry_limit;
	logic [2:0]  mode;
	logic [31:0] status;

	mfs_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.tick    (tick)
	);

	mfs_pulse_div u_div (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.half_cycle (half_cycle),
		.divider    (s_r.ctrl[MFS_F_DIV +: 4]),
		.enable     (div_en),
		.pulse      (div_pulse)
	);

	always_comb
	begin
		s_nxt = s_r;
		mode = s_r.ctrl[MFS_F_MODE +: 3];
		clear_req = 1'b0;

		// bus: read data sampled on the first cycle, writes land on the acknowledge edge
		s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
		// settled before the status word reads it, so a status read never sees last pass's value
		cap_limiting = s_r.ctrl[MFS_F_CAPEN] & (s_r.cap_ref < speed_ref_in);
		status = 32'h0;
		status[2:0] = s_r.state;
		status[3] = cap_limiting;
		status[4] = s_r.latched;
		status[5] = s_r.retry_pend;
		status[6] = ~s_r.fault_n;
		status[7] = s_r.alarm;
		status[8] = motor_lock;
		status[9] = s_r.first_start;
		if (avs_read && !s_r.ack)
		begin
			case (avs_address[4:2])
				MFS_REG_CTRL:   s_nxt.rdata = s_r.ctrl;
				MFS_REG_SPEED:  s_nxt.rdata = s_r.speed;
				MFS_REG_BRAKE:  s_nxt.rdata = s_r.brake;
				MFS_REG_LIMIT:  s_nxt.rdata = s_r.limit;
				MFS_REG_BEMF:   s_nxt.rdata = s_r.bemf;
				MFS_REG_STATUS: s_nxt.rdata = status;
				default:        s_nxt.rdata = 32'h0;
			endcase
		end
		if (avs_write && s_r.ack)
		begin
			case (avs_address[4:2])
				MFS_REG_CTRL:
				begin
					s_nxt.ctrl = mfs_merge(s_r.ctrl, avs_writedata, avs_byteenable) & MFS_CTRL_MASK;
					clear_req = avs_byteenable[3] & avs_writedata[MFS_F_CLEAR];
				end
				MFS_REG_SPEED: s_nxt.speed = mfs_merge(s_r.speed, avs_writedata, avs_byteenable);
				MFS_REG_BRAKE: s_nxt.brake = mfs_merge(s_r.brake, avs_writedata, avs_byteenable);
				MFS_REG_LIMIT: s_nxt.limit = mfs_merge(s_r.limit, avs_writedata, avs_byteenable);
				MFS_REG_BEMF:  s_nxt.bemf = mfs_merge(s_r.bemf, avs_writedata, avs_byteenable) & MFS_BEMF_MASK;
				default:       s_nxt.bemf = s_r.bemf;
			endcase
		end

		// faults: a new latched event wins over a clear in the same cycle
		s_nxt.latched = fault_in.latched | (s_r.latched & ~clear_req);
		retry_limit = s_r.slow_seen ? MFS_RETRY_SLOW_MS : MFS_RETRY_FAST_MS;
		if (fault_in.retry_slow || fault_in.retry_fast)
		begin
			s_nxt.retry_pend = 1'b1;
			s_nxt.retry_cnt = 16'h0;
			if (fault_in.retry_slow)
				s_nxt.slow_seen = 1'b1;
		end
		else if (s_r.retry_pend && tick)
		begin
			if (s_r.retry_cnt + 16'h1 >= retry_limit)
			begin
				s_nxt.retry_pend = 1'b0;
				s_nxt.slow_seen = 1'b0;
				s_nxt.retry_cnt = 16'h0;
			end
			else
				s_nxt.retry_cnt = s_r.retry_cnt + 16'h1;
		end
		// latched holds off past any retry expiry, giving latched the top priority
		outputs_off = s_r.latched | fault_in.latched | s_r.retry_pend
			| fault_in.retry_slow | fault_in.retry_fast;
		// reporting is registered in the same cycle as the response, well inside the allowed lag
		s_nxt.fault_n = ~(outputs_off | (fault_in.report_only & ~s_r.ctrl[MFS_F_ALARM]));
		s_nxt.alarm = s_r.ctrl[MFS_F_ALARM] & (outputs_off | fault_in.report_only);

		// supply current cap works on its own reference so releasing it recovers gently
		cap_up = {1'b0, s_r.cap_ref} + {1'b0, MFS_CAP_STEP};
		if (!s_r.ctrl[MFS_F_CAPEN])
			s_nxt.cap_ref = speed_ref_in;
		else if (tick)
		begin
			if (supply_current_est > s_r.limit[31:16])
				s_nxt.cap_ref = (s_r.cap_ref > MFS_CAP_STEP) ? s_r.cap_ref - MFS_CAP_STEP : 16'h0;
			else if (cap_up[15:0] < speed_ref_in && !cap_up[16])
				s_nxt.cap_ref = cap_up[15:0];
			else
				s_nxt.cap_ref = speed_ref_in;
		end
		capped_ref = cap_limiting ? s_r.cap_ref : speed_ref_in;

		// ramp toward the stop target, one step per millisecond
		ramp_tgt = (s_r.state == MFS_SPIN) ? s_r.speed[31:16] : s_r.speed[15:0];
		ramp_sum = {1'b0, ramp_tgt} + {1'b0, MFS_RAMP_STEP};
		ramp_dn = ({1'b0, s_r.ref_val} > ramp_sum) ? s_r.ref_val - MFS_RAMP_STEP : ramp_tgt;

		case (s_r.state)
			MFS_RUN:
			begin
				s_nxt.ref_val = capped_ref;
				s_nxt.last_angle = commutation_angle;
				if (stop_cmd)
				begin
					s_nxt.brake_cnt = 16'h0;
					case (mode)
						MFS_STOP_HSBRK, MFS_STOP_LSBRK, MFS_STOP_ALIGN:
							if (motor_speed < s_r.speed[15:0])
								s_nxt.state = MFS_BRAKE;
							else
								s_nxt.state = MFS_DECEL;
						MFS_STOP_SPIN:
							s_nxt.state = MFS_SPIN;
						default:
							s_nxt.state = MFS_HIZ;
					endcase
				end
			end
			MFS_DECEL:
			begin
				s_nxt.last_angle = commutation_angle;
				if (tick)
					s_nxt.ref_val = ramp_dn;
				if (motor_speed <= s_r.speed[15:0])
					s_nxt.state = MFS_BRAKE;
			end
			MFS_SPIN:
			begin
				if (tick)
					s_nxt.ref_val = ramp_dn;
				if (s_r.ref_val <= s_r.speed[31:16])
					s_nxt.state = MFS_HIZ;
			end
			MFS_BRAKE:
			begin
				s_nxt.ref_val = 16'h0;
				if (s_r.brake_cnt >= s_r.brake[15:0])
					s_nxt.state = MFS_HIZ;
				else if (tick)
					s_nxt.brake_cnt = s_r.brake_cnt + 16'h1;
			end
			MFS_HIZ:
			begin
				s_nxt.ref_val = 16'h0;
				if (start_cmd)
					s_nxt.state = MFS_RUN;
			end
			default:
				s_nxt.state = MFS_HIZ;
		endcase

		// power stage drive
		align_angle = s_r.ctrl[MFS_F_ANGSEL] ? s_r.last_angle : s_r.brake[31:16];
		s_nxt.cur_lim = 16'hffff;
		case (s_r.state)
			MFS_RUN, MFS_DECEL, MFS_SPIN:
				s_nxt.gate = drive_gate;
			MFS_BRAKE:
			begin
				case (mode)
					MFS_STOP_HSBRK: s_nxt.gate = '{hs: 3'h7, ls: 3'h0};
					MFS_STOP_LSBRK: s_nxt.gate = '{hs: 3'h0, ls: 3'h7};
					MFS_STOP_ALIGN:
					begin
						s_nxt.gate = mfs_align_pattern(align_angle);
						s_nxt.cur_lim = s_r.limit[15:0];
					end
					default:        s_nxt.gate = '0;
				endcase
			end
			default:
				s_nxt.gate = '0;
		endcase
		if (outputs_off)
			s_nxt.gate = '0;
		s_nxt.ref_out = outputs_off ? 16'h0 : s_r.ref_val;

		// speed pulse output
		s_nxt.ol_d = open_loop;
		if (wake)
			s_nxt.first_start = 1'b1;
		else if (s_r.ol_d && !open_loop)
			s_nxt.first_start = 1'b0;
		driving = (s_r.state != MFS_HIZ) && !outputs_off;
		pulse_active = driving
			| (s_r.ctrl[MFS_F_EXTENT] & (bemf_level >= s_r.bemf[15:0]));
		ol_hold = open_loop & ((s_r.ctrl[MFS_F_POLICY +: 2] == MFS_OL_HIGH)
			| ((s_r.ctrl[MFS_F_POLICY +: 2] == MFS_OL_FIRST) & ~s_r.first_start));
		div_en = pulse_active & ~motor_lock & ~ol_hold;
		if (motor_lock)
			s_nxt.pulse = 1'b1;
		else if (ol_hold)
			s_nxt.pulse = 1'b1;
		else
			s_nxt.pulse = pulse_active & div_pulse;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_r <= '0;
			s_r.state <= MFS_HIZ;
			s_r.ctrl <= MFS_CTRL_RST;
			s_r.first_start <= 1'b1;
			s_r.fault_n <= 1'b1;
			s_r.cur_lim <= 16'hffff;
		end
		else
			s_r <= s_nxt;
	end

	assign avs_waitrequest     = (avs_read | avs_write) & ~s_r.ack;
	assign avs_readdata        = s_r.rdata;
	assign gate_out            = s_r.gate;
	assign phase_current_limit = s_r.cur_lim;
	assign speed_ref_out       = s_r.ref_out;
	assign speed_pulse_output  = s_r.pulse;
	assign fault_out_n         = s_r.fault_n;
	assign alarm_out           = s_r.alarm;
endmodule // mfs_supervisor

// ===== verification/mfs_motor_model.sv
`timescale 1ns/1ns
module mfs_motor_model import mfs_pkg::*; (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// power stage drive
	input  wire mfs_gate_s   gate_out,
	input  wire logic [15:0] speed_ref_out,
	// motor feedback
	output logic [15:0]      motor_speed,
	output logic [15:0]      bemf_level,
	output logic             half_cycle
);
	logic [1:0] phase_r;
	assign bemf_level = motor_speed;
	assign half_cycle = phase_r == 2'h3 && motor_speed != 16'h0000;
	// a driven motor follows the reference at once; a free one only coasts down slowly
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			motor_speed <= 16'h0000;
			phase_r <= 2'h0;
		end
		else
		begin
			phase_r <= phase_r + 2'h1;
			if (gate_out != '0)
				motor_speed <= speed_ref_out;
			else if (motor_speed != 16'h0000)
				motor_speed <= motor_speed - 16'h0001;
		end
	end
endmodule // mfs_motor_model

// ===== verification/mfs_supervisor_assertions.sv
`timescale 1ns/1ns
module mfs_supervisor_assertions import mfs_pkg::*; (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// bus handshake
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	// drive and pins
	input wire logic        motor_lock,
	input wire mfs_fault_s  fault_in,
	input wire mfs_gate_s   gate_out,
	input wire logic [15:0] speed_ref_out,
	input wire logic        fault_out_n,
	input wire logic        alarm_out,
	input wire logic        speed_pulse_output
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic act;
	assign act = fault_in.latched | fault_in.retry_slow | fault_in.retry_fast;
	sequence bus_rise; $rose(avs_read || avs_write); endsequence
	sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
	sequence latch_quiet; fault_in.latched ##1 !avs_write [*8]; endsequence

	chk_bus_wait: assert property (bus_rise |-> one_wait)
		else $error("bus access did not take one wait cycle");
	chk_fault_pin: assert property (act |=> !fault_out_n)
		else $error("fault pin not low after actionable fault");
	chk_gates_off: assert property (act |=> gate_out == '0)
		else $error("gates on during actionable fault");
	chk_ref_off: assert property (act |-> ##[1:2] speed_ref_out == 16'h0000)
		else $error("reference not zero with outputs off");
	chk_latch_hold: assert property (latch_quiet |-> gate_out == '0 && !fault_out_n)
		else $error("latched fault released without clear");
	chk_alarm_cause: assert property ($rose(alarm_out) |-> !fault_out_n || $past(fault_in.report_only))
		else $error("alarm raised without a fault");
	chk_report_pin: assert property (fault_in.report_only |=> !fault_out_n || alarm_out)
		else $error("report fault shown on no pin");
	chk_lock_high: assert property (motor_lock [*2] |-> speed_pulse_output)
		else $error("speed pulse not high during lock");
endmodule // mfs_supervisor_assertions

bind mfs_supervisor mfs_supervisor_assertions u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .motor_lock(motor_lock), .fault_in(fault_in),
	.gate_out(gate_out), .speed_ref_out(speed_ref_out), .fault_out_n(fault_out_n), .alarm_out(alarm_out),
	.speed_pulse_output(speed_pulse_output));

// ===== verification/mfs_supervisor_tb.sv
`timescale 1ns/1ns
module mfs_supervisor_tb import mfs_pkg::*;;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] ref_in;
		mfs_gate_s   gates;
		logic [15:0] lim;
	} mfs_row_s;
	typedef struct packed {
		logic [31:0] ctrl;
		logic        ol;
		logic        wk;
		logic [7:0]  edges;
		logic [7:0]  highs;
	} mfs_pc_s;
	localparam mfs_gate_s DRIVE = 6'h0a;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic        stop_cmd = 1'b0;
	logic        start_cmd = 1'b0;
	logic        open_loop = 1'b0;
	logic        motor_lock = 1'b0;
	logic        wake = 1'b0;
	logic [15:0] speed_ref_in = 16'h0000;
	logic [15:0] supply_current_est = 16'h0000;
	mfs_fault_s  fault_in = 4'h0;
	logic [31:0] avs_readdata, q;
	logic [15:0] motor_speed, bemf_level, speed_ref_out, phase_current_limit;
	logic        avs_waitrequest, half_cycle, fault_out_n, alarm_out, speed_pulse_output, prev;
	mfs_gate_s   gate_out;
	int          errors = 0;
	int          compares = 0;
	int          n, e, h;
	mfs_row_s rows [10] = '{'{32'h40, 16'h200, 6'h00, 16'h4}, '{32'h41, 16'h200, 6'h00, 16'h4},
		'{32'h42, 16'h200, 6'h07, 16'h400}, '{32'h43, 16'h200, 6'h38, 16'h400}, '{32'h43, 16'h80, 6'h38, 16'h4},
		'{32'h44, 16'h200, 6'h00, 16'h400}, '{32'h45, 16'h200, 6'h0e, 16'h400},
		'{32'h445, 16'h200, 6'h31, 16'h400}, '{32'h46, 16'h200, 6'h00, 16'h4}, '{32'h47, 16'h200, 6'h00, 16'h4}};
	mfs_pc_s pc [7] = '{'{32'h40, 1'b0, 1'b0, 8'd6, 8'd24}, '{32'hc0, 1'b0, 1'b0, 8'd2, 8'd24},
		'{32'h50, 1'b1, 1'b0, 8'd0, 8'd48}, '{32'h60, 1'b1, 1'b1, 8'd6, 8'd24}, '{32'h60, 1'b0, 1'b0, 8'd6, 8'd24},
		'{32'h60, 1'b1, 1'b0, 8'd0, 8'd48}, '{32'h40, 1'b1, 1'b0, 8'd6, 8'd24}};

	mfs_supervisor #(.TICK_CYCLES(10)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_cmd(stop_cmd), .start_cmd(start_cmd),
		.speed_ref_in(speed_ref_in), .motor_speed(motor_speed), .supply_current_est(supply_current_est),
		.bemf_level(bemf_level), .commutation_angle(16'h8000), .drive_gate(DRIVE), .half_cycle(half_cycle),
		.open_loop(open_loop), .motor_lock(motor_lock), .wake(wake), .speed_ref_out(speed_ref_out),
		.phase_current_limit(phase_current_limit), .gate_out(gate_out), .fault_in(fault_in),
		.fault_out_n(fault_out_n), .alarm_out(alarm_out), .speed_pulse_output(speed_pulse_output));
	mfs_motor_model MOTOR (.clk_sys(clk_sys), .reset_n(reset_n), .gate_out(gate_out), .speed_ref_out(speed_ref_out),
		.motor_speed(motor_speed), .bemf_level(bemf_level), .half_cycle(half_cycle));

	always #10 clk_sys = ~clk_sys;

	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// an answer that never comes is left to the watchdog
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic start_motor();
		start_cmd <= 1'b1;
		tick(1);
		start_cmd <= 1'b0;
		tick(30);
	endtask
	// 48 samples hold a whole number of periods for dividers 1 and 3
	task automatic measure();
		e = 0;
		h = 0;
		prev = speed_pulse_output;
		repeat (48)
		begin
			tick(1);
			e += speed_pulse_output && !prev;
			h += speed_pulse_output;
			prev = speed_pulse_output;
		end
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		tick(80000);
		errors++;
		complete_run();
	end

	initial
	begin
		tick(12);
		reset_n <= 1'b1;
		bus(0, 5'h00, 0, 4'hf);
		chk("ctrl reset", MFS_CTRL_RST, q);
		bus(0, 5'h18, 0, 4'hf);
		chk("unmapped read", 0, q);
		bus(0, 5'h14, 0, 4'hf);
		chk("status state", 4, q[2:0]);
		bus(1, 5'h04, 32'h0100_0100, 4'hf);
		bus(1, 5'h08, 32'h0000_0003, 4'hf);
		bus(1, 5'h0c, 32'h0100_0123, 4'hf);
		foreach (rows[i])
		begin
			bus(1, 5'h00, rows[i].ctrl, 4'hf);
			speed_ref_in <= rows[i].ref_in;
			start_motor();
			stop_cmd <= 1'b1;
			tick(1);
			stop_cmd <= 1'b0;
			n = 0;
			while (gate_out === DRIVE && n < rows[i].lim)
			begin
				tick(1);
				n++;
			end
			chk("stop gates", rows[i].gates, gate_out);
			chk("decel time", rows[i].lim > 16'h4, n >= 150);
			if (rows[i].gates != 0)
			begin
				chk("current limit", rows[i].ctrl[2:0] == MFS_STOP_ALIGN ? 16'h0123 : 16'hffff, phase_current_limit);
				n = 0;
				while (gate_out === rows[i].gates && n < 100)
				begin
					tick(1);
					n++;
				end
				chk("brake span", 1, n >= 20 && n <= 32);
				chk("after brake", 0, gate_out);
			end
			tick(5);
		end
		bus(1, 5'h00, 32'h40, 4'hf);
		start_motor();
		for (int i = 0; i < 2; i++)
		begin
			bus(1, 5'h00, i ? 32'h840 : 32'h40, 4'hf);
			fault_in <= 4'h1;
			tick(3);
			chk("report pin", i, fault_out_n);
			chk("report alarm", i, alarm_out);
			fault_in <= 4'h0;
			tick(3);
		end
		// slow and fast together first, so the longer retry time has to win
		for (int i = 0; i < 2; i++)
		begin
			fault_in <= i ? 4'h2 : 4'h6;
			tick(3);
			chk("retry pin", 0, fault_out_n);
			chk("retry alarm", 1, alarm_out);
			chk("retry gates", 0, gate_out);
			fault_in <= 4'h0;
			n = 0;
			while (fault_out_n !== 1'b1 && n < 12000)
			begin
				tick(1);
				n++;
			end
			e = (i ? MFS_RETRY_FAST_MS : MFS_RETRY_SLOW_MS) * 10;
			chk("retry time", 1, n > e - 15 && n < e + 15);
			tick(3);
			chk("retry recovery", DRIVE, gate_out);
		end
		fault_in <= 4'ha;
		tick(2);
		fault_in <= 4'h0;
		tick(MFS_RETRY_FAST_MS * 10 + 200);
		chk("latched pin", 0, fault_out_n);
		chk("latched gates", 0, gate_out);
		bus(1, 5'h00, 32'h8000_0000, 4'h8);
		n = 0;
		while (fault_out_n !== 1'b1 && n < MFS_CLEAR_LAG_MS * 10)
		begin
			tick(1);
			n++;
		end
		chk("clear pin", 1, fault_out_n);
		tick(3);
		chk("clear gates", DRIVE, gate_out);
		foreach (pc[i])
		begin
			bus(1, 5'h00, pc[i].ctrl, 4'hf);
			wake <= pc[i].wk;
			open_loop <= pc[i].ol;
			tick(1);
			wake <= 1'b0;
			tick(30);
			measure();
			chk("pulse edges", pc[i].edges, e);
			chk("pulse highs", pc[i].highs, h);
		end
		motor_lock <= 1'b1;
		tick(3);
		measure();
		chk("lock highs", 48, h);
		motor_lock <= 1'b0;
		open_loop <= 1'b0;
		// coast stop: extent 0 silences the pulse at once, extent 1 runs on until the cutoff
		bus(1, 5'h10, 32'h180, 4'hf);
		for (int i = 0; i < 2; i++)
		begin
			bus(1, 5'h00, i ? 32'h48 : 32'h40, 4'hf);
			stop_cmd <= 1'b1;
			tick(1);
			stop_cmd <= 1'b0;
			tick(3);
			measure();
			chk("extent edges", i ? 6 : 0, e);
			tick(200);
			measure();
			chk("extent off", 0, h);
			start_motor();
		end
		bus(1, 5'h00, 32'h1040, 4'hf);
		supply_current_est <= 16'h0200;
		tick(100);
		bus(0, 5'h14, 0, 4'hf);
		chk("cap status", 1, q[3]);
		chk("cap limiting", 1, speed_ref_out < speed_ref_in);
		reset_n <= 1'b0;
		tick(2);
		chk("reset gates", 0, gate_out);
		chk("reset pin", 1, fault_out_n);
		chk("reset ref", 0, speed_ref_out);
		reset_n <= 1'b1;
		tick(2);
		complete_run();
	end
endmodule // mfs_supervisor_tb
